// [rtl/sdseq_defs.svh]
// Constants of the shutdown sequencer: register indices, entry fields,
// reset values and timing counts.
// Assumes a 100 MHz clock; an APB byte address is four times an index.
`ifndef SDSEQ_DEFS_SVH
`define SDSEQ_DEFS_SVH

`define SDSEQ_REG_SWRST 8'h00
`define SDSEQ_REG_BIAS 8'h04
`define SDSEQ_REG_MIDRAIL 8'h05
`define SDSEQ_REG_PHONES_GAIN 8'h0e
`define SDSEQ_REG_LINE_GAIN 8'h0f
`define SDSEQ_REG_CONVERTER 8'h12
`define SDSEQ_REG_CLOCK 8'h16
`define SDSEQ_REG_SERVO 8'h43
`define SDSEQ_REG_PHONES 8'h5a
`define SDSEQ_REG_LINE 8'h5e
`define SDSEQ_REG_PUMP 8'h62
`define SDSEQ_REG_DUMMY 8'hff
`define SDSEQ_REG_STEPSEL 8'h6c
`define SDSEQ_REG_STEPWORD 8'h6d
`define SDSEQ_REG_LAUNCH 8'h6f
`define SDSEQ_REG_STATUS 8'h70

`define SDSEQ_LAUNCH_GO_BIT 8
`define SDSEQ_LAUNCH_IDX 5:0
`define SDSEQ_STATUS_BUSY_BIT 0
`define SDSEQ_STATUS_IDX 13:8

`define SDSEQ_E_ADDR 7:0
`define SDSEQ_E_START 11:8
`define SDSEQ_E_WM1 14:12
`define SDSEQ_E_DATA 23:16
`define SDSEQ_E_DELAY 27:24
`define SDSEQ_E_EOS 28

`define SDSEQ_CTL_RST 8'h00
`define SDSEQ_NSLOT 10
`define SDSEQ_NOSLOT 4'hf
`define SDSEQ_NSTEP 64
`define SDSEQ_SHUT_IDX 6'h19
`define SDSEQ_SHUT_LAST 6'h27
`define SDSEQ_IDX_MAX 6'h3f

`define SDSEQ_CLK_NS 10
`define SDSEQ_TICK_NS 62500
`define SDSEQ_TICK_CYC (`SDSEQ_TICK_NS / `SDSEQ_CLK_NS)
`define SDSEQ_DLY_OFFSET 16'd8
`define SDSEQ_POR_MIN_NS 9500
`define SDSEQ_POR_CYC ((`SDSEQ_POR_MIN_NS + `SDSEQ_CLK_NS - 1) / `SDSEQ_CLK_NS)

`endif

// [rtl/sdseq_pkg.sv]
// Types shared by the shutdown sequencer files.
// Assumes sdseq_defs.svh for the numeric constants.
package sdseq_pkg;
  typedef enum logic [2:0] {
    SDSEQ_IDLE = 3'b001,
    SDSEQ_WRITE = 3'b010,
    SDSEQ_WAIT = 3'b100
  } sdseq_state_e;
  typedef logic [5:0] sdseq_idx_t;
endpackage : sdseq_pkg

// [rtl/sdseq_por.sv]
// Power-on reset gate from two supply monitor levels.
// Assumes the monitor levels are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "sdseq_defs.svh"
module sdseq_por (
  input wire logic clk,
  input wire logic resetn,
  input wire logic analog_supply_ok,
  input wire logic core_supply_ok,
  output var logic por_n
);
  logic [1:0] a_sync_r;
  logic [1:0] c_sync_r;
  logic [9:0] cnt_r;
  logic [9:0] ok_run_r;
  logic both_ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_sync_r <= 2'h0;
      c_sync_r <= 2'h0;
    end else begin
      a_sync_r <= {a_sync_r[0], analog_supply_ok};
      c_sync_r <= {c_sync_r[0], core_supply_ok};
    end
  end

  assign both_ok = a_sync_r[1] & c_sync_r[1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 10'h0;
      por_n <= 1'b0;
    end else if (!both_ok) begin
      // RULE_14: drop on supply loss
      cnt_r <= 10'h0;
      por_n <= 1'b0;
    end else if (!por_n) begin
      // RULE_13: hold minimum period
      if (cnt_r == 10'(`SDSEQ_POR_CYC - 1)) begin
        por_n <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 10'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ok_run_r <= 10'h0;
    end else if (!both_ok) begin
      ok_run_r <= 10'h0;
    end else if (ok_run_r != 10'h3ff) begin
      ok_run_r <= ok_run_r + 10'h1;
    end
  end

  a_por_min: assert property (@(posedge clk) disable iff (!resetn) // RULE_13
    $rose(por_n) |-> ok_run_r >= 10'(`SDSEQ_POR_CYC))
    else $error("reset released too early");
  a_por_drop: assert property (@(posedge clk) disable iff (!resetn) // RULE_14
    !both_ok |=> !por_n)
    else $error("reset not asserted on supply loss");
  c_por_release: cover property (@(posedge clk) disable iff (!resetn)
    $rose(por_n));
endmodule : sdseq_por
`default_nettype wire

// [rtl/sdseq_top.sv]
// Shutdown write sequencer with APB registers and power-on reset gating.
// Assumes an APB master on clk and asynchronous supply monitor levels.
// Operation
// RULE_01: Host writes 0119h to launch register
// RULE_02: Launch starts at index 25, ascending
// RULE_03: Write field, wait delay, halt on end
// RULE_04: First step writes 77h to line control
// RULE_05: Steps 26-34 disable outputs, servo, converters
// RULE_06: Final steps drop bias, midrail, reference
// RULE_07: Delay code 0 waits 0.5625ms, longer above
// RULE_08: Whole shutdown takes about 350ms; the default table here takes about 296ms (4741 ticks)
// RULE_09: Busy flag high while program runs
// RULE_10: Software reset restores default step table
// RULE_11: During power-on reset writes are discarded
// RULE_12: After release registers default, writes accepted
// RULE_13: Power-on reset lasts at least 9.5us
// RULE_14: Supply loss asserts power-on reset again
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sdseq_defs.svh"
module sdseq_top #(
  parameter int TICK_CYC = `SDSEQ_TICK_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic analog_supply_ok,
  input wire logic core_supply_ok,
  output wire logic por_n,
  output var logic sequencer_running_flag,
  output var sdseq_pkg::sdseq_idx_t step_index,
  output wire logic [7:0] bias_ctl,
  output wire logic [7:0] midrail_ctl,
  output wire logic [7:0] phones_gain_ctl,
  output wire logic [7:0] line_gain_ctl,
  output wire logic [7:0] converter_ctl,
  output wire logic [7:0] clock_ctl,
  output wire logic [7:0] servo_ctl,
  output wire logic [7:0] phones_ctl,
  output wire logic [7:0] line_ctl,
  output wire logic [7:0] pump_ctl
);
  import sdseq_pkg::*;

  function automatic logic [3:0] slot_of(input logic [7:0] a);
    if (a == `SDSEQ_REG_BIAS) slot_of = 4'h0;
    else if (a == `SDSEQ_REG_MIDRAIL) slot_of = 4'h1;
    else if (a == `SDSEQ_REG_PHONES_GAIN) slot_of = 4'h2;
    else if (a == `SDSEQ_REG_LINE_GAIN) slot_of = 4'h3;
    else if (a == `SDSEQ_REG_CONVERTER) slot_of = 4'h4;
    else if (a == `SDSEQ_REG_CLOCK) slot_of = 4'h5;
    else if (a == `SDSEQ_REG_SERVO) slot_of = 4'h6;
    else if (a == `SDSEQ_REG_PHONES) slot_of = 4'h7;
    else if (a == `SDSEQ_REG_LINE) slot_of = 4'h8;
    else if (a == `SDSEQ_REG_PUMP) slot_of = 4'h9;
    else slot_of = `SDSEQ_NOSLOT;
  endfunction : slot_of

  function automatic logic [31:0] mk(input logic [7:0] a, input logic [3:0] s,
      input logic [2:0] w, input logic [7:0] d, input logic [3:0] dl,
      input logic e);
    mk = {3'h0, e, dl, d, 1'b0, w, s, a};
  endfunction : mk

  // RULE_06: default shutdown entries
  function automatic logic [31:0] step_default(input logic [5:0] i);
    case (i)
      6'd25: step_default = mk(`SDSEQ_REG_LINE, 4'h0, 3'h7, 8'h77, 4'h0, 1'b0);
      6'd26: step_default = mk(`SDSEQ_REG_PHONES, 4'h0, 3'h7, 8'h77, 4'h0, 1'b0);
      6'd27: step_default = mk(`SDSEQ_REG_PHONES, 4'h0, 3'h7, 8'h00, 4'h0, 1'b0);
      6'd28: step_default = mk(`SDSEQ_REG_LINE, 4'h0, 3'h7, 8'h00, 4'h0, 1'b0);
      6'd29: step_default = mk(`SDSEQ_REG_SERVO, 4'h0, 3'h3, 8'h00, 4'h0, 1'b0);
      6'd30: step_default = mk(`SDSEQ_REG_PUMP, 4'h0, 3'h0, 8'h00, 4'h0, 1'b0);
      6'd31: step_default = mk(`SDSEQ_REG_CONVERTER, 4'h2, 3'h1, 8'h00, 4'h0,
          1'b0);
      6'd32: step_default = mk(`SDSEQ_REG_CLOCK, 4'h1, 3'h0, 8'h00, 4'h0, 1'b0);
      6'd33: step_default = mk(`SDSEQ_REG_PHONES_GAIN, 4'h0, 3'h1, 8'h00, 4'h0,
          1'b0);
      6'd34: step_default = mk(`SDSEQ_REG_LINE_GAIN, 4'h0, 3'h1, 8'h00, 4'h0,
          1'b0);
      6'd35: step_default = mk(`SDSEQ_REG_BIAS, 4'h0, 3'h0, 8'h00, 4'h0, 1'b0);
      6'd36: step_default = mk(`SDSEQ_REG_MIDRAIL, 4'h0, 3'h0, 8'h00, 4'hc, 1'b0);
      6'd37: step_default = mk(`SDSEQ_REG_MIDRAIL, 4'h0, 3'h0, 8'h00, 4'h9, 1'b0);
      6'd38: step_default = mk(`SDSEQ_REG_MIDRAIL, 4'h0, 3'h7, 8'h00, 4'h0, 1'b0);
      6'd39: step_default = mk(`SDSEQ_REG_BIAS, 4'h0, 3'h1, 8'h00, 4'h0, 1'b1);
      default: step_default = mk(`SDSEQ_REG_DUMMY, 4'h0, 3'h0, 8'h00, 4'h0, 1'b0);
    endcase
  endfunction : step_default

  logic [7:0] ctl_r [`SDSEQ_NSLOT];
  logic [31:0] step_r [`SDSEQ_NSTEP];
  logic [5:0] sel_r;
  sdseq_state_e st_r;
  logic [15:0] units_r;
  logic [31:0] pre_r;
  logic [7:0] ridx;
  logic [3:0] rslot;
  logic wr_go;
  logic sw_rst;
  logic launch_go;
  logic clr;
  logic done_w;
  logic [31:0] cur;
  logic [3:0] cur_slot;
  logic [15:0] mask_w;
  logic [15:0] val_w;

  sdseq_por u_por (
    .clk(clk),
    .resetn(resetn),
    .analog_supply_ok(analog_supply_ok),
    .core_supply_ok(core_supply_ok),
    .por_n(por_n)
  );

  assign ridx = paddr[9:2];
  assign rslot = slot_of(ridx);
  // RULE_11: writes need reset released
  assign wr_go = psel && penable && pready && pwrite && !pslverr && por_n;
  assign sw_rst = wr_go && ridx == `SDSEQ_REG_SWRST;
  // RULE_01: launch value starts program
  assign launch_go = wr_go && ridx == `SDSEQ_REG_LAUNCH &&
      pwdata[`SDSEQ_LAUNCH_GO_BIT] && st_r == SDSEQ_IDLE;
  assign clr = !por_n || sw_rst;
  assign cur = step_r[step_index];
  assign cur_slot = slot_of(cur[`SDSEQ_E_ADDR]);
  assign mask_w = ((16'h2 << cur[`SDSEQ_E_WM1]) - 16'h1) << cur[`SDSEQ_E_START];
  assign val_w = {8'h00, cur[`SDSEQ_E_DATA]} << cur[`SDSEQ_E_START];
  assign done_w = st_r == SDSEQ_WAIT && pre_r == 32'h0 && units_r == 16'h1;

  assign bias_ctl = ctl_r[0];
  assign midrail_ctl = ctl_r[1];
  assign phones_gain_ctl = ctl_r[2];
  assign line_gain_ctl = ctl_r[3];
  assign converter_ctl = ctl_r[4];
  assign clock_ctl = ctl_r[5];
  assign servo_ctl = ctl_r[6];
  assign phones_ctl = ctl_r[7];
  assign line_ctl = ctl_r[8];
  assign pump_ctl = ctl_r[9];

  // Answer one cycle after setup so every bus output is a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
        pslverr <= 1'b1;
      end else if (ridx == `SDSEQ_REG_STATUS) begin
        prdata[`SDSEQ_STATUS_BUSY_BIT] <= sequencer_running_flag;
        prdata[`SDSEQ_STATUS_IDX] <= step_index;
      end else if (ridx == `SDSEQ_REG_STEPSEL) begin
        prdata[5:0] <= sel_r;
      end else if (ridx == `SDSEQ_REG_STEPWORD) begin
        prdata <= step_r[sel_r];
      end else if (ridx == `SDSEQ_REG_LAUNCH || ridx == `SDSEQ_REG_SWRST) begin
        prdata <= 32'h0;
      end else if (rslot != `SDSEQ_NOSLOT) begin
        prdata[7:0] <= ctl_r[rslot];
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // RULE_12: controls default until release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `SDSEQ_NSLOT; i++) ctl_r[i] <= `SDSEQ_CTL_RST;
    end else if (clr) begin
      for (int i = 0; i < `SDSEQ_NSLOT; i++) ctl_r[i] <= `SDSEQ_CTL_RST;
    end else if (st_r == SDSEQ_WRITE && cur_slot != `SDSEQ_NOSLOT) begin
      // RULE_03: masked field write
      ctl_r[cur_slot] <= (ctl_r[cur_slot] & ~mask_w[7:0]) |
          (val_w[7:0] & mask_w[7:0]);
    end else if (wr_go && rslot != `SDSEQ_NOSLOT) begin
      ctl_r[rslot] <= pwdata[7:0];
    end
  end

  // RULE_10: table restored on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `SDSEQ_NSTEP; i++) step_r[i] <= step_default(6'(i));
      sel_r <= 6'h0;
    end else if (clr) begin
      for (int i = 0; i < `SDSEQ_NSTEP; i++) step_r[i] <= step_default(6'(i));
      sel_r <= 6'h0;
    end else if (wr_go && ridx == `SDSEQ_REG_STEPSEL) begin
      sel_r <= pwdata[5:0];
    end else if (wr_go && ridx == `SDSEQ_REG_STEPWORD) begin
      step_r[sel_r] <= {3'h0, pwdata[28:0]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= SDSEQ_IDLE;
      step_index <= 6'h0;
      sequencer_running_flag <= 1'b0;
    end else if (clr) begin
      st_r <= SDSEQ_IDLE;
      step_index <= 6'h0;
      sequencer_running_flag <= 1'b0;
    end else begin
      case (st_r)
        SDSEQ_IDLE: begin
          if (launch_go) begin
            // RULE_02: start at written index
            step_index <= pwdata[`SDSEQ_LAUNCH_IDX];
            st_r <= SDSEQ_WRITE;
            // RULE_09: busy while running
            sequencer_running_flag <= 1'b1;
          end
        end
        SDSEQ_WRITE: st_r <= SDSEQ_WAIT;
        SDSEQ_WAIT: begin
          if (done_w) begin
            // RULE_03: halt after end step
            if (cur[`SDSEQ_E_EOS] || step_index == `SDSEQ_IDX_MAX) begin
              st_r <= SDSEQ_IDLE;
              sequencer_running_flag <= 1'b0;
            end else begin
              step_index <= step_index + 6'h1;
              st_r <= SDSEQ_WRITE;
            end
          end
        end
        default: st_r <= SDSEQ_IDLE;
      endcase
    end
  end

  // RULE_07: wait of (2^code + 8) ticks
  // RULE_08: tick sets total shutdown time
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      units_r <= 16'h0;
      pre_r <= 32'h0;
    end else if (st_r == SDSEQ_WRITE) begin
      units_r <= (16'h1 << cur[`SDSEQ_E_DELAY]) + `SDSEQ_DLY_OFFSET;
      pre_r <= 32'(TICK_CYC - 1);
    end else if (st_r == SDSEQ_WAIT && pre_r == 32'h0) begin
      units_r <= units_r - 16'h1;
      pre_r <= 32'(TICK_CYC - 1);
    end else if (st_r == SDSEQ_WAIT) begin
      pre_r <= pre_r - 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_launch_start: assert property (launch_go && // RULE_02
      pwdata[5:0] == 6'h19 |=> st_r == SDSEQ_WRITE && step_index == 6'h19)
    else $error("launch did not start at index 25");
  a_first_step: assert property (launch_go && // RULE_04
      step_r[25] == step_default(6'd25) && pwdata[5:0] == 6'h19
      ##1 !clr |=> line_ctl == 8'h77)
    else $error("first step did not write line control");
  a_step_ascend: assert property (done_w && !cur[`SDSEQ_E_EOS] && // RULE_03
      !clr && step_index != `SDSEQ_IDX_MAX |=>
      step_index == $past(step_index) + 6'h1 && st_r == SDSEQ_WRITE)
    else $error("step index did not advance");
  a_halt_eos: assert property (done_w && cur[`SDSEQ_E_EOS] |=> // RULE_03
      st_r == SDSEQ_IDLE && !sequencer_running_flag)
    else $error("sequencer did not halt at end step");
  a_busy_state: assert property (sequencer_running_flag == // RULE_09
      (st_r != SDSEQ_IDLE))
    else $error("busy flag disagrees with state");
  a_delay_load: assert property (st_r == SDSEQ_WAIT && // RULE_07
      $past(st_r) == SDSEQ_WRITE && $past(cur[`SDSEQ_E_DELAY]) == 4'h0 |->
      units_r == 16'd9)
    else $error("shortest delay is not nine ticks");
  a_por_hold: assert property (!por_n |=> // RULE_11
      ctl_r[8] == `SDSEQ_CTL_RST && ctl_r[7] == `SDSEQ_CTL_RST &&
      st_r == SDSEQ_IDLE)
    else $error("register changed during power-on reset");
  a_swrst_restore: assert property (sw_rst |=> // RULE_10
      step_r[25] == step_default(6'd25) && step_r[39] == step_default(6'd39))
    else $error("software reset left table modified");
  c_launch: cover property (launch_go && pwdata[5:0] == 6'h19);
  c_halt: cover property (done_w && step_index == `SDSEQ_SHUT_LAST);
  c_long_wait: cover property (st_r == SDSEQ_WAIT && units_r == 16'd4104);
endmodule : sdseq_top
`default_nettype wire

// [tb/sdseq_top_tb_top.sv]
// Bench for the shutdown sequencer: APB master, integer model of the
// control registers and of the default shutdown table.
// Assumes sdseq_top built with a short tick so long delays stay cheap.
`timescale 1ns/1ns
`default_nettype none
`include "sdseq_defs.svh"
module sdseq_top_tb_top;
  import sdseq_pkg::*;
  localparam int TICK = 4;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic analog_supply_ok = 1'b1;
  logic core_supply_ok = 1'b1;
  wire por_n;
  logic busy;
  sdseq_idx_t step_index;
  wire [7:0] ctl [10];
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int mdl [256];
  int regs [10] = '{'h04, 'h05, 'h0e, 'h0f, 'h12, 'h16, 'h43, 'h5a, 'h5e,
    'h62};
  // Rows: target, start bit, width, data, delay code, end flag
  int tbl [15][6] = '{'{'h5e, 0, 8, 'h77, 0, 0}, '{'h5a, 0, 8, 'h77, 0, 0},
    '{'h5a, 0, 8, 0, 0, 0}, '{'h5e, 0, 8, 0, 0, 0}, '{'h43, 0, 4, 0, 0, 0},
    '{'h62, 0, 1, 0, 0, 0}, '{'h12, 2, 2, 0, 0, 0}, '{'h16, 1, 1, 0, 0, 0},
    '{'h0e, 0, 2, 0, 0, 0}, '{'h0f, 0, 2, 0, 0, 0}, '{'h04, 0, 1, 0, 0, 0},
    '{'h05, 0, 1, 0, 12, 0}, '{'h05, 0, 1, 0, 9, 0}, '{'h05, 0, 8, 0, 0, 0},
    '{'h04, 0, 2, 0, 0, 1}};

  sdseq_top #(.TICK_CYC(TICK)) dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_supply_ok(analog_supply_ok), .core_supply_ok(core_supply_ok),
    .por_n(por_n), .sequencer_running_flag(busy), .step_index(step_index),
    .bias_ctl(ctl[0]), .midrail_ctl(ctl[1]), .phones_gain_ctl(ctl[2]),
    .line_gain_ctl(ctl[3]), .converter_ctl(ctl[4]), .clock_ctl(ctl[5]),
    .servo_ctl(ctl[6]), .phones_ctl(ctl[7]), .line_ctl(ctl[8]),
    .pump_ctl(ctl[9]));

  always #5 clk = ~clk;

  // Hang guard, sized well above the full shutdown at this tick
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  // One transfer; the extra edge at the end keeps psel from being driven
  // twice in one time step by a following call
  task automatic apb(input logic w, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check_val(32'd0, 32'd1, "pready wait");
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
      input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    check_val(r, exp, "read data");
    check_val({31'h0, e}, {31'h0, experr}, "read error");
  endtask : rd_chk

  task automatic wait_for(input int sel, input int v, input int bound);
    int n;
    n = 0;
    while (n < bound && (sel == 0 ? step_index !== 6'(v) :
        sel == 1 ? busy !== 1'(v) : por_n !== 1'(v))) begin
      @(posedge clk);
      n++;
    end
    if (n >= bound) check_val(32'd0, 32'd1, "bounded wait");
  endtask : wait_for

  function automatic int slot(input int a);
    for (int k = 0; k < 10; k++) if (regs[k] == a) return k;
    return 0;
  endfunction : slot

  task automatic fill_random();
    int v;
    for (int k = 0; k < 10; k++) begin
      v = ($urandom & 'hff) | 'h01;
      wr(8'(regs[k]), 32'(v));
      mdl[regs[k]] = v;
    end
  endtask : fill_random

  task automatic run_shutdown();
    int t0, tp, msk, a, k, total;
    logic [31:0] r;
    logic e;
    total = 0;
    t0 = cyc;
    wr(`SDSEQ_REG_LAUNCH, 32'h0000_0119);
    tp = cyc;
    for (int i = 0; i < 15; i++) begin
      if (i > 0) begin
        wait_for(0, 25 + i, 20000);
        check_val(32'(cyc - tp), 32'(1 + ((1 << tbl[i-1][4]) + 8) * TICK),
          "step spacing");
        tp = cyc;
      end
      total += 1 + ((1 << tbl[i][4]) + 8) * TICK;
      a = tbl[i][0];
      msk = ((1 << tbl[i][2]) - 1) << tbl[i][1];
      mdl[a] = (mdl[a] & ~msk) | ((tbl[i][3] << tbl[i][1]) & msk);
      repeat (2) @(posedge clk);
      k = slot(a);
      check_val(32'(ctl[k]), 32'(mdl[a]), "step write");
      check_val(32'(busy), 32'd1, "busy");
      if (i == 0) begin
        apb(1'b0, `SDSEQ_REG_STATUS, 32'h0, r, e);
        check_val({r[13:8], r[0]}, {6'h19, 1'b1}, "status");
      end
    end
    wait_for(1, 0, 300);
    check_val(32'(cyc - t0 < total + 12), 32'd1, "run length");
    for (int j = 0; j < 10; j++) begin
      check_val(32'(ctl[j]), 32'(mdl[regs[j]]), "final");
    end
    $display("test shutdown done");
  endtask : run_shutdown

  initial begin
    int t0;
    int v;
    void'($urandom(78873));
    foreach (mdl[j]) mdl[j] = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t0 = cyc;
    wr(`SDSEQ_REG_LINE, 32'h0000_00ff);
    wait_for(2, 1, 2000);
    check_val(32'(cyc - t0 >= `SDSEQ_POR_CYC), 32'd1, "por length");
    rd_chk(`SDSEQ_REG_LINE, 32'h0, 1'b0);
    $display("test power on done");
    for (int k = 0; k < 10; k++) begin
      rd_chk(8'(regs[k]), 32'h0, 1'b0);
      v = $urandom & 'hff;
      wr(8'(regs[k]), 32'(v));
      rd_chk(8'(regs[k]), 32'(v), 1'b0);
      check_val(32'(ctl[k]), 32'(v), "ctl port");
      mdl[regs[k]] = v;
    end
    rd_chk(8'h01, 32'h0, 1'b1);
    $display("test registers done");
    // Host-modified entry 25 ends the program at once
    wr(`SDSEQ_REG_STEPSEL, 32'h0000_0019);
    wr(`SDSEQ_REG_STEPWORD, 32'h1012_705e);
    rd_chk(`SDSEQ_REG_STEPSEL, 32'h0000_0019, 1'b0);
    rd_chk(`SDSEQ_REG_STEPWORD, 32'h1012_705e, 1'b0);
    wr(`SDSEQ_REG_LAUNCH, 32'h0000_0119);
    wait_for(1, 0, 200);
    check_val(32'(ctl[8]), 32'h12, "edited step");
    wr(`SDSEQ_REG_SWRST, 32'h0);
    for (int k = 0; k < 10; k++) begin
      check_val(32'(ctl[k]), 32'h0, "soft reset");
      mdl[regs[k]] = 0;
    end
    // Default entry 25 is back: line control, width 8, data 77h
    wr(`SDSEQ_REG_STEPSEL, 32'h0000_0019);
    rd_chk(`SDSEQ_REG_STEPWORD, 32'h0077_705e, 1'b0);
    $display("test soft reset done");
    fill_random();
    // default table back after soft reset
    run_shutdown();
    for (int s = 0; s < 2; s++) begin
      wr(`SDSEQ_REG_LINE, 32'h0000_00a5);
      if (s == 0) analog_supply_ok <= 1'b0;
      else core_supply_ok <= 1'b0;
      repeat (5) @(posedge clk);
      check_val(32'(por_n), 32'd0, "supply loss");
      check_val(32'(ctl[8]), 32'h0, "ctl in reset");
      wr(`SDSEQ_REG_LINE, 32'h0000_0055);
      analog_supply_ok <= 1'b1;
      core_supply_ok <= 1'b1;
      wait_for(2, 1, 2000);
      rd_chk(`SDSEQ_REG_LINE, 32'h0, 1'b0);
    end
    $display("test supply loss done");
    stop_test();
  end
endmodule : sdseq_top_tb_top
`default_nettype wire
